// *** asla_alu.v ***
// Summary of operation
// - Rotate right moves bits down, old bit 0 into top bit.
// - Rotate through carry: old carry to top, old bit 0 to carry.
// - Right rotates set sign; carry and zero change only for through-carry form.
// - Left shift by 1, 2 or 4 fills zeros; updates carry, sign, zero.
// - Two or four place left shift leaves last bit out in carry.
// - Logical right shift moves down one and puts zero on top.
// - Arithmetic right shifts copy the top bit, keeping the sign.
// - Every right shift step sends bit 0 into carry.
// - Right shifts set carry and zero; sign only on logical form.
// - Subtract: acc minus source; sets borrow, sign, zero, overflow.
// - Borrow subtract also takes away carry; same four flags.
// - Wide variant may take 8-bit source high byte from prefix register.
// - Wide variant byte swap exchanges halves; only sign changes.
// - Nibble swap in each byte; only sign changes.
// - Source xor: acc xor source; sign and zero only.
// - Bit xor: carry xor selected acc bit; no other flag.
//
// Purpose: Accumulator datapath slice with flags
// Assumes: Decoder presents one operation per valid cycle
// Notes: Results and flags register one cycle after op_valid_i
`timescale 1ns/10ps
`include "asla_consts.vh"
module asla_alu #(
  parameter ACC_W = `ASLA_ACC_W_DEF
) (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Operation from decoder
  input wire op_valid_i,
  input wire [`ASLA_OP_W-1:0] op_i,
  input wire [ACC_W-1:0] src_i,
  input wire src_narrow_i,
  input wire [7:0] prefix_register_i,
  input wire [3:0] bit_index_i,
  // Accumulator load from register file
  input wire acc_load_i,
  input wire [ACC_W-1:0] acc_load_data_i,
  // Results
  output wire [ACC_W-1:0] acc_o,
  output wire carry_o,
  output wire sign_o,
  output wire zero_o,
  output wire signed_wrap_flag_o
);
  reg [ACC_W-1:0] acc_ff;
  reg carry_ff;
  reg sign_ff;
  reg zero_ff;
  reg wrap_ff;
  reg [ACC_W-1:0] nxt_acc;
  reg nxt_carry;
  reg nxt_sign;
  reg nxt_zero;
  reg nxt_wrap;
  reg [ACC_W-1:0] src_full;
  reg bit_sel;
  wire [ACC_W-1:0] sh_res;
  wire sh_carry;
  wire [ACC_W-1:0] sx_res;
  wire sx_borrow;
  wire sx_wrap;

  // High byte of a narrow source comes from the prefix register
  generate
    if (ACC_W == 16)
    begin : g_wide_src
      always @*
      begin
        src_full = src_i;
        if (src_narrow_i)
        begin
          src_full = {prefix_register_i, src_i[7:0]};
        end
      end
    end
    else
    begin : g_narrow_src
      // Narrow part has no prefix byte to borrow, source passes as is
      always @*
      begin
        src_full = src_i;
      end
    end
  endgenerate

  // Index wraps inside the width; narrow codes above 7 unsupported
  always @*
  begin
    bit_sel = acc_ff[bit_index_i[$clog2(ACC_W)-1:0]];
  end

  asla_shifter #(
    .ACC_W(ACC_W)
  ) u_shifter (
    .op_i(op_i),
    .acc_i(acc_ff),
    .carry_i(carry_ff),
    .res_o(sh_res),
    .carry_o(sh_carry)
  );

  // Source equal to the accumulator is kept out by the decoder
  asla_subxor #(
    .ACC_W(ACC_W)
  ) u_subxor (
    .op_i(op_i),
    .acc_i(acc_ff),
    .src_i(src_full),
    .carry_i(carry_ff),
    .res_o(sx_res),
    .borrow_o(sx_borrow),
    .wrap_o(sx_wrap)
  );

  always @*
  begin
    nxt_acc = acc_ff;
    nxt_carry = carry_ff;
    nxt_sign = sign_ff;
    nxt_zero = zero_ff;
    nxt_wrap = wrap_ff;
    if (acc_load_i)
    begin
      nxt_acc = acc_load_data_i;
      nxt_sign = acc_load_data_i[ACC_W-1];
      nxt_zero = (acc_load_data_i == {ACC_W{1'b0}});
    end
    else if (op_valid_i)
    begin
      case (op_i)
        `ASLA_OP_ROT_RIGHT:
        begin
          nxt_acc = sh_res;
          nxt_sign = sh_res[ACC_W-1];
        end
        `ASLA_OP_ROT_RIGHT_THRU_CARRY:
        begin
          nxt_acc = sh_res;
          nxt_carry = sh_carry;
          nxt_sign = sh_res[ACC_W-1];
          nxt_zero = (sh_res == {ACC_W{1'b0}});
        end
        `ASLA_OP_ARITH_LEFT_SHIFT, `ASLA_OP_ARITH_LEFT_SHIFT_TWO,
        `ASLA_OP_ARITH_LEFT_SHIFT_FOUR, `ASLA_OP_LOGICAL_RIGHT_SHIFT:
        begin
          nxt_acc = sh_res;
          nxt_carry = sh_carry;
          nxt_sign = sh_res[ACC_W-1];
          nxt_zero = (sh_res == {ACC_W{1'b0}});
        end
        `ASLA_OP_ARITH_RIGHT_SHIFT, `ASLA_OP_ARITH_RIGHT_SHIFT_TWO,
        `ASLA_OP_ARITH_RIGHT_SHIFT_FOUR:
        begin
          // Sign bit cannot change here, so the flag is left alone
          nxt_acc = sh_res;
          nxt_carry = sh_carry;
          nxt_zero = (sh_res == {ACC_W{1'b0}});
        end
        `ASLA_OP_SUBTRACT, `ASLA_OP_MINUS_WITH_BORROW:
        begin
          nxt_acc = sx_res;
          nxt_carry = sx_borrow;
          nxt_sign = sx_res[ACC_W-1];
          nxt_zero = (sx_res == {ACC_W{1'b0}});
          nxt_wrap = sx_wrap;
        end
        `ASLA_OP_BYTE_SWAP:
        begin
          if (ACC_W == 16)
          begin
            nxt_acc = sx_res;
            nxt_sign = sx_res[ACC_W-1];
          end
        end
        `ASLA_OP_NIBBLE_SWAP:
        begin
          nxt_acc = sx_res;
          nxt_sign = sx_res[ACC_W-1];
        end
        `ASLA_OP_SRC_XOR:
        begin
          nxt_acc = sx_res;
          nxt_sign = sx_res[ACC_W-1];
          nxt_zero = (sx_res == {ACC_W{1'b0}});
        end
        `ASLA_OP_BIT_XOR:
        begin
          nxt_carry = carry_ff ^ bit_sel;
        end
        default:
        begin
          nxt_acc = acc_ff;
        end
      endcase
    end
  end

  always @(posedge clock_i)
  begin
    if (reset_i)
    begin
      acc_ff <= `ASLA_RESET_ACC;
      carry_ff <= `ASLA_RESET_FLAG;
      sign_ff <= `ASLA_RESET_FLAG;
      zero_ff <= `ASLA_RESET_FLAG;
      wrap_ff <= `ASLA_RESET_FLAG;
    end
    else
    begin
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      sign_ff <= nxt_sign;
      zero_ff <= nxt_zero;
      wrap_ff <= nxt_wrap;
    end
  end

  assign acc_o = acc_ff;
  assign carry_o = carry_ff;
  assign sign_o = sign_ff;
  assign zero_o = zero_ff;
  assign signed_wrap_flag_o = wrap_ff;
endmodule // asla_alu

// *** asla_consts.vh ***
// Purpose: Constants for the accumulator shift/logic datapath slice
// Assumes: Included by every design file of the block
// Notes: Operation codes are local to this block
`ifndef ASLA_CONSTS_VH
`define ASLA_CONSTS_VH
`define ASLA_OP_W 4
`define ASLA_OP_NOP 4'h0
`define ASLA_OP_ROT_RIGHT 4'h1
`define ASLA_OP_ROT_RIGHT_THRU_CARRY 4'h2
`define ASLA_OP_ARITH_LEFT_SHIFT 4'h3
`define ASLA_OP_ARITH_LEFT_SHIFT_TWO 4'h4
`define ASLA_OP_ARITH_LEFT_SHIFT_FOUR 4'h5
`define ASLA_OP_LOGICAL_RIGHT_SHIFT 4'h6
`define ASLA_OP_ARITH_RIGHT_SHIFT 4'h7
`define ASLA_OP_ARITH_RIGHT_SHIFT_TWO 4'h8
`define ASLA_OP_ARITH_RIGHT_SHIFT_FOUR 4'h9
`define ASLA_OP_SUBTRACT 4'ha
`define ASLA_OP_MINUS_WITH_BORROW 4'hb
`define ASLA_OP_BYTE_SWAP 4'hc
`define ASLA_OP_NIBBLE_SWAP 4'hd
`define ASLA_OP_SRC_XOR 4'he
`define ASLA_OP_BIT_XOR 4'hf
`define ASLA_ACC_W_DEF 16
`define ASLA_RESET_ACC 16'h0000
`define ASLA_RESET_FLAG 1'b0
`endif

// *** asla_shifter.v ***
// Purpose: Combinational shift and rotate unit
// Assumes: Single operation per cycle, width of 8 or 16
// Notes: Carry out is the last bit pushed out of the word
`timescale 1ns/10ps
`include "asla_consts.vh"
module asla_shifter #(
  parameter ACC_W = `ASLA_ACC_W_DEF
) (
  // Operands
  input wire [`ASLA_OP_W-1:0] op_i,
  input wire [ACC_W-1:0] acc_i,
  input wire carry_i,
  // Results
  output reg [ACC_W-1:0] res_o,
  output reg carry_o
);
  always @*
  begin
    res_o = acc_i;
    carry_o = carry_i;
    case (op_i)
      `ASLA_OP_ROT_RIGHT:
      begin
        res_o = {acc_i[0], acc_i[ACC_W-1:1]};
      end
      `ASLA_OP_ROT_RIGHT_THRU_CARRY:
      begin
        res_o = {carry_i, acc_i[ACC_W-1:1]};
        carry_o = acc_i[0];
      end
      `ASLA_OP_ARITH_LEFT_SHIFT:
      begin
        res_o = {acc_i[ACC_W-2:0], 1'b0};
        carry_o = acc_i[ACC_W-1];
      end
      `ASLA_OP_ARITH_LEFT_SHIFT_TWO:
      begin
        res_o = {acc_i[ACC_W-3:0], 2'b00};
        carry_o = acc_i[ACC_W-2];
      end
      `ASLA_OP_ARITH_LEFT_SHIFT_FOUR:
      begin
        res_o = {acc_i[ACC_W-5:0], 4'h0};
        carry_o = acc_i[ACC_W-4];
      end
      `ASLA_OP_LOGICAL_RIGHT_SHIFT:
      begin
        res_o = {1'b0, acc_i[ACC_W-1:1]};
        carry_o = acc_i[0];
      end
      `ASLA_OP_ARITH_RIGHT_SHIFT:
      begin
        res_o = {acc_i[ACC_W-1], acc_i[ACC_W-1:1]};
        carry_o = acc_i[0];
      end
      `ASLA_OP_ARITH_RIGHT_SHIFT_TWO:
      begin
        res_o = {{2{acc_i[ACC_W-1]}}, acc_i[ACC_W-1:2]};
        carry_o = acc_i[1];
      end
      `ASLA_OP_ARITH_RIGHT_SHIFT_FOUR:
      begin
        res_o = {{4{acc_i[ACC_W-1]}}, acc_i[ACC_W-1:4]};
        carry_o = acc_i[3];
      end
      default:
      begin
        res_o = acc_i;
        carry_o = carry_i;
      end
    endcase
  end
endmodule // asla_shifter

// *** asla_subxor.v ***
// Purpose: Subtract, borrow subtract, swaps and source exclusive-or
// Assumes: Source already widened to accumulator width
// Notes: Carry out is a borrow on subtraction
`timescale 1ns/10ps
`include "asla_consts.vh"
module asla_subxor #(
  parameter ACC_W = `ASLA_ACC_W_DEF
) (
  // Operands
  input wire [`ASLA_OP_W-1:0] op_i,
  input wire [ACC_W-1:0] acc_i,
  input wire [ACC_W-1:0] src_i,
  input wire carry_i,
  // Results
  output reg [ACC_W-1:0] res_o,
  output reg borrow_o,
  output reg wrap_o
);
  reg [ACC_W:0] diff;
  reg use_c;
  integer k;
  always @*
  begin
    use_c = (op_i == `ASLA_OP_MINUS_WITH_BORROW);
    // Extra top bit of the difference is the borrow
    diff = {1'b0, acc_i} - {1'b0, src_i} - {{ACC_W{1'b0}}, use_c & carry_i};
    res_o = acc_i;
    borrow_o = carry_i;
    wrap_o = 1'b0;
    case (op_i)
      `ASLA_OP_SUBTRACT, `ASLA_OP_MINUS_WITH_BORROW:
      begin
        res_o = diff[ACC_W-1:0];
        borrow_o = diff[ACC_W];
        // Signs differ and result sign differs from minuend
        wrap_o = (acc_i[ACC_W-1] ^ src_i[ACC_W-1]) &
                 (acc_i[ACC_W-1] ^ diff[ACC_W-1]);
      end
      `ASLA_OP_BYTE_SWAP:
      begin
        if (ACC_W == 16)
        begin
          // Halves by width keep the narrow build free of reversed ranges
          res_o = {acc_i[ACC_W/2-1:0], acc_i[ACC_W-1:ACC_W/2]};
        end
      end
      `ASLA_OP_NIBBLE_SWAP:
      begin
        for (k = 0; k < ACC_W; k = k + 8)
        begin
          res_o[k+:8] = {acc_i[k+:4], acc_i[k+4+:4]};
        end
      end
      `ASLA_OP_SRC_XOR:
      begin
        res_o = acc_i ^ src_i;
      end
      default:
      begin
        res_o = acc_i;
      end
    endcase
  end
endmodule // asla_subxor

// *** asla_dec_model.sv ***
// Purpose: Decoder and register file stand-in feeding the datapath
// Assumes: Requests come from the bench
// Notes: Source is always a register other than the accumulator
`timescale 1ns/10ps
module asla_dec_model #(
  parameter ACC_W = 16
) (
  // Requests
  input wire [3:0] req_op_i,
  input wire [ACC_W-1:0] req_src_i,
  input wire [3:0] req_index_i,
  // To datapath
  output wire [3:0] op_o,
  output wire [ACC_W-1:0] src_o,
  output wire [3:0] bit_index_o
);
  assign op_o = req_op_i;
  // Register file value, never the accumulator itself
  assign src_o = req_src_i;
  // Narrow part only encodes bits zero to seven
  assign bit_index_o = (ACC_W == 8) ? {1'b0, req_index_i[2:0]} : req_index_i;
endmodule // asla_dec_model

// *** asla_alu_checker.sv ***
// Purpose: Port level checks of the datapath
// Assumes: One clock, synchronous reset
// Notes: Narrow source subtract left to the bench
`timescale 1ns/10ps
`include "asla_consts.vh"
module asla_alu_checker #(
  parameter ACC_W = 16
) (
  input wire clock_i,
  input wire reset_i,
  input wire op_valid_i,
  input wire [3:0] op_i,
  input wire [ACC_W-1:0] src_i,
  input wire src_narrow_i,
  input wire [3:0] bit_index_i,
  input wire acc_load_i,
  input wire [ACC_W-1:0] acc_o,
  input wire carry_o,
  input wire sign_o,
  input wire zero_o,
  input wire signed_wrap_flag_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire tk = op_valid_i && !acc_load_i;
  // Sign extended difference: overflow when its two top bits differ
  wire [ACC_W:0] sdiff = {acc_o[ACC_W-1], acc_o} - {src_i[ACC_W-1], src_i};
  a_rot_right: assert property (tk && op_i == `ASLA_OP_ROT_RIGHT |=>
    acc_o == $past({acc_o[0], acc_o[ACC_W-1:1]}) && $stable({carry_o, zero_o}))
    else $error("rotate right wrong");
  a_rot_carry: assert property (tk && op_i == `ASLA_OP_ROT_RIGHT_THRU_CARRY |=>
    acc_o == $past({carry_o, acc_o[ACC_W-1:1]}) && carry_o == $past(acc_o[0]))
    else $error("rotate through carry wrong");
  a_left_four: assert property (tk && op_i == `ASLA_OP_ARITH_LEFT_SHIFT_FOUR |=>
    acc_o == $past(acc_o << 4) && carry_o == $past(acc_o[ACC_W-4]))
    else $error("left shift four wrong");
  a_logic_right: assert property (tk && op_i == `ASLA_OP_LOGICAL_RIGHT_SHIFT |=>
    acc_o == $past(acc_o >> 1) && carry_o == $past(acc_o[0]) && !sign_o)
    else $error("logical right shift wrong");
  a_arith_right: assert property (tk && op_i == `ASLA_OP_ARITH_RIGHT_SHIFT_TWO |=>
    acc_o == $past($signed(acc_o) >>> 2) && carry_o == $past(acc_o[1]) && $stable(sign_o))
    else $error("arith right shift wrong");
  a_sub_value: assert property (tk && op_i == `ASLA_OP_SUBTRACT && !src_narrow_i |=>
    {carry_o, acc_o} == $past({1'b0, acc_o} - {1'b0, src_i}))
    else $error("subtract wrong");
  a_sub_wrap: assert property (tk && op_i == `ASLA_OP_SUBTRACT && !src_narrow_i |=>
    signed_wrap_flag_o == $past(sdiff[ACC_W] ^ sdiff[ACC_W-1]))
    else $error("subtract overflow flag wrong");
  a_borrow_sub: assert property (tk && op_i == `ASLA_OP_MINUS_WITH_BORROW && !src_narrow_i |=>
    {carry_o, acc_o} == $past({1'b0, acc_o} - {1'b0, src_i} - carry_o))
    else $error("borrow subtract wrong");
  a_byte_swap: assert property (tk && op_i == `ASLA_OP_BYTE_SWAP && ACC_W == 16 |=>
    acc_o == $past({acc_o[ACC_W/2-1:0], acc_o[ACC_W-1:ACC_W/2]}) &&
    $stable({carry_o, zero_o, signed_wrap_flag_o}))
    else $error("byte swap wrong");
  a_nibble_swap: assert property (tk && op_i == `ASLA_OP_NIBBLE_SWAP |=>
    acc_o[3:0] == $past(acc_o[7:4]) && $stable({carry_o, zero_o, signed_wrap_flag_o}))
    else $error("nibble swap wrong");
  a_bit_xor: assert property (tk && op_i == `ASLA_OP_BIT_XOR |=>
    carry_o == $past(carry_o ^ acc_o[bit_index_i]) && $stable({acc_o, sign_o, zero_o}))
    else $error("bit xor wrong");
  a_idle_hold: assert property (!op_valid_i && !acc_load_i |=>
    $stable({acc_o, carry_o, sign_o, zero_o, signed_wrap_flag_o}))
    else $error("outputs moved while idle");
endmodule // asla_alu_checker

// *** tb_top.sv ***
// Purpose: Scenario bench of the datapath
// Assumes: Wide variant, 40 MHz clock
// Notes: Expected words hold acc then carry, sign, zero, wrap
`timescale 1ns/10ps
`include "asla_consts.vh"
module tb_top;
  reg clock_i = 1'b0;
  reg reset_i = 1'b1;
  reg op_valid = 1'b0;
  reg acc_load = 1'b0;
  reg narrow = 1'b0;
  reg [3:0] r_op = 4'h0;
  reg [3:0] r_idx = 4'h0;
  reg [15:0] r_src = 16'h0000;
  reg [15:0] ld_data = 16'h0000;
  reg [7:0] prefix_register = 8'h00;
  wire [3:0] op;
  wire [3:0] idx;
  wire [15:0] src;
  wire [15:0] acc;
  wire c, s, z, w;
  integer bad_count = 0;
  integer num_checks = 0;
  integer cyc = 0;
  asla_dec_model #(.ACC_W(16)) u_dec (.req_op_i(r_op), .req_src_i(r_src),
    .req_index_i(r_idx), .op_o(op), .src_o(src), .bit_index_o(idx));
  asla_alu #(.ACC_W(16)) DUT (.clock_i(clock_i), .reset_i(reset_i), .op_valid_i(op_valid),
    .op_i(op), .src_i(src), .src_narrow_i(narrow), .prefix_register_i(prefix_register),
    .bit_index_i(idx), .acc_load_i(acc_load), .acc_load_data_i(ld_data), .acc_o(acc),
    .carry_o(c), .sign_o(s), .zero_o(z), .signed_wrap_flag_o(w));
  initial forever #12.5 clock_i = ~clock_i;
  // Ceiling well above the 48 or so cycles the scenarios need
  always @(posedge clock_i)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task complete_run;
  begin
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task load(input [15:0] v);
  begin
    op_valid = 1'b0;
    acc_load = 1'b1;
    ld_data = v;
    @(posedge clock_i);
    #2;
    acc_load = 1'b0;
  end
  endtask
  // Back to back ops: valid stays high between calls
  task step(input [3:0] o, input [15:0] sv, input [3:0] bi, input [19:0] exp);
  begin
    op_valid = 1'b1;
    r_op = o;
    r_src = sv;
    r_idx = bi;
    @(posedge clock_i);
    #2;
    chk(exp);
  end
  endtask
  task chk(input [19:0] exp);
  begin
    num_checks = num_checks + 1;
    if ({acc, c, s, z, w} !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, {acc, c, s, z, w}, exp);
    end
  end
  endtask
  // Idle cycle, then a load that beats a pending op
  task t_hold;
  begin
    op_valid = 1'b0;
    r_op = `ASLA_OP_ROT_RIGHT;
    @(posedge clock_i);
    #2;
    chk({16'h2c4a, 4'h8});
    op_valid = 1'b1;
    r_op = `ASLA_OP_ROT_RIGHT_THRU_CARRY;
    acc_load = 1'b1;
    ld_data = 16'h0000;
    @(posedge clock_i);
    #2;
    chk({16'h0000, 4'ha});
    acc_load = 1'b0;
    op_valid = 1'b0;
    $display("hold test done");
  end
  endtask
  task t_rot;
  begin
    load(16'ha345);
    step(`ASLA_OP_BIT_XOR, 16'h0, 4'h0, {16'ha345, 4'hc});
    step(`ASLA_OP_ROT_RIGHT, 16'h0, 4'h0, {16'hd1a2, 4'hc});
    step(`ASLA_OP_ROT_RIGHT_THRU_CARRY, 16'h0, 4'h0, {16'he8d1, 4'h4});
    $display("rotate test done");
  end
  endtask
  task t_left;
  begin
    load(16'he345);
    step(`ASLA_OP_ARITH_LEFT_SHIFT, 16'h0, 4'h0, {16'hc68a, 4'hc});
    step(`ASLA_OP_ARITH_LEFT_SHIFT_TWO, 16'h0, 4'h0, {16'h1a28, 4'h8});
    load(16'he345);
    step(`ASLA_OP_ARITH_LEFT_SHIFT_FOUR, 16'h0, 4'h0, {16'h3450, 4'h0});
    $display("left shift test done");
  end
  endtask
  task t_right;
  begin
    load(16'ha345);
    step(`ASLA_OP_LOGICAL_RIGHT_SHIFT, 16'h0, 4'h0, {16'h51a2, 4'h8});
    load(16'h0003);
    step(`ASLA_OP_ARITH_RIGHT_SHIFT, 16'h0, 4'h0, {16'h0001, 4'h8});
    step(`ASLA_OP_ARITH_RIGHT_SHIFT, 16'h0, 4'h0, {16'h0000, 4'ha});
    load(16'h8000);
    step(`ASLA_OP_ARITH_RIGHT_SHIFT_FOUR, 16'h0, 4'h0, {16'hf800, 4'h4});
    step(`ASLA_OP_ARITH_RIGHT_SHIFT_TWO, 16'h0, 4'h0, {16'hfe00, 4'h4});
    $display("right shift test done");
  end
  endtask
  task t_sub;
  begin
    load(16'h2345);
    step(`ASLA_OP_SUBTRACT, 16'h1250, 4'h0, {16'h10f5, 4'h0});
    step(`ASLA_OP_SUBTRACT, 16'h1250, 4'h0, {16'hfea5, 4'hc});
    step(`ASLA_OP_SUBTRACT, 16'h7fff, 4'h0, {16'h7ea6, 4'h1});
    load(16'h2345);
    step(`ASLA_OP_BIT_XOR, 16'h0, 4'h0, {16'h2345, 4'h9});
    step(`ASLA_OP_MINUS_WITH_BORROW, 16'h1250, 4'h0, {16'h10f4, 4'h0});
    load(16'h2345);
    narrow = 1'b1;
    prefix_register = 8'h12;
    // Top source byte must be replaced by the prefix
    step(`ASLA_OP_SUBTRACT, 16'hff50, 4'h0, {16'h10f5, 4'h0});
    narrow = 1'b0;
    $display("subtract test done");
  end
  endtask
  task t_swap;
  begin
    load(16'h2345);
    step(`ASLA_OP_BYTE_SWAP, 16'h0, 4'h0, {16'h4523, 4'h0});
    step(`ASLA_OP_NIBBLE_SWAP, 16'h0, 4'h0, {16'h5432, 4'h0});
    step(`ASLA_OP_NOP, 16'h0, 4'h0, {16'h5432, 4'h0});
    load(16'h2345);
    step(`ASLA_OP_SRC_XOR, 16'h0f0f, 4'h0, {16'h2c4a, 4'h0});
    step(`ASLA_OP_BIT_XOR, 16'h0, 4'hb, {16'h2c4a, 4'h8});
    $display("swap and xor test done");
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clock_i);
    #2;
    reset_i = 1'b0;
    @(posedge clock_i);
    #2;
    t_rot;
    t_left;
    t_right;
    t_sub;
    t_swap;
    t_hold;
    complete_run;
  end
endmodule // tb_top
bind asla_alu asla_alu_checker #(.ACC_W(ACC_W)) u_chk (.clock_i(clock_i), .reset_i(reset_i),
  .op_valid_i(op_valid_i), .op_i(op_i), .src_i(src_i), .src_narrow_i(src_narrow_i),
  .bit_index_i(bit_index_i), .acc_load_i(acc_load_i), .acc_o(acc_o), .carry_o(carry_o),
  .sign_o(sign_o), .zero_o(zero_o), .signed_wrap_flag_o(signed_wrap_flag_o));
